// ==== rtl/cpe_pkg.sv ====
package cpe_pkg;
	// Register byte addresses on the Avalon slave
	localparam logic [15:0] INJECT_OFS = 16'h8ec0;
	localparam logic [15:0] FAULT_CTRL_OFS = 16'h8e88;
	localparam logic [15:0] SYNDROME_OFS = 16'h8e90;
	localparam logic [15:0] SEC_CTRL_OFS = 16'h8e18;
	localparam logic [15:0] IRQ_STAT_OFS = 16'h8f00;
	localparam logic [15:0] IRQ_CLR_OFS = 16'h8f04;
	localparam logic [15:0] IRQ_EN_OFS = 16'h8f08;
	// Injection register fields
	localparam int INJ_CCT_BIT = 3;
	localparam int INJ_CCD_BIT = 2;
	localparam int INJ_WCT_BIT = 1;
	localparam int INJ_WCD_BIT = 0;
	localparam logic [3:0] INJECT_RESET = 4'h0;
	// Fault control and secure control fields
	localparam int FAULT_IRQ_EN_BIT = 3;
	localparam logic FAULT_IRQ_EN_RESET = 1'b1;
	localparam int PERMIT_BIT = 1;
	// Syndrome fields
	localparam int SYN_VALID_BIT = 30;
	localparam int SYN_OVF_BIT = 27;
	localparam int SYN_CE_LSB = 24;
	localparam int SYN_SRC_LSB = 8;
	localparam logic [1:0] CE_CORRECTED = 2'h2;
	localparam logic [1:0] CE_CLEAR_CODE = 2'h3;
	localparam logic [7:0] SERR_NONE = 8'h00;
	localparam logic [7:0] SERR_TAG = 8'h07;
	localparam logic [7:0] SERR_DATA = 8'h08;
	localparam logic [7:0] SRC_CONFIG_CACHE = 8'h08;
	localparam logic [2:0] WALK_SRC_MAX = 3'h7;
	// Event status bit positions
	localparam int EV_TAG_BIT = 0;
	localparam int EV_DATA_BIT = 1;
	localparam int EV_OVF_BIT = 2;
	localparam int EV_W = 3;

	// Cache fill request, parity bits computed by the cache
	typedef struct packed {
		logic valid;
		logic tagPar;
		logic dataPar;
	} cpe_fill_s;

	// Cache lookup hit, stored parity vs recomputed parity
	typedef struct packed {
		logic valid;
		logic tagBad;
		logic dataBad;
		logic [2:0] level;
	} cpe_use_s;

	// Avalon-MM request
	typedef struct packed {
		logic read;
		logic write;
		logic [15:0] address;
		logic [31:0] writedata;
		logic nonsecure;
	} cpe_bus_s;
endpackage

// ==== rtl/cpe_parity_corrupt.sv ====
`timescale 1ns/1ps
`default_nettype none
// Inverts the stored parity bits of one cache fill when injection asks
module cpe_parity_corrupt
	import cpe_pkg::*;
(
	input wire cpe_fill_s fillIn, // Fill from the cache
	input wire logic tagInject, // Corrupt tag parity
	input wire logic dataInject, // Corrupt data parity
	output cpe_fill_s fillOut // Fill as it is stored
);
	// Only the fill itself is touched; stored entries never change here
	assign fillOut.valid = fillIn.valid;
	assign fillOut.tagPar = fillIn.tagPar ^ tagInject;
	assign fillOut.dataPar = fillIn.dataPar ^ dataInject;
endmodule
`default_nettype wire

// ==== rtl/cpe_error_injector.sv ====
// Operation
// - Config cache tag parity inverted while set
// - Config cache data parity inverted while set
// - Walk cache tag parity inverted while set
// - Walk cache data parity inverted while set
// - Fault raised on use, not on write
// - Tag error hides data error
// - Injected errors correctable, not to manager
// - Non-secure access RAZ/WI unless permitted; IRQ status, clear and enable always open, secure control always RAZ/WI
// - Corrected error sets CE to 0b10
// - Source code: walk 0-7, config 8
// - Reliability interrupt gated by enable bit
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module cpe_error_injector
	import cpe_pkg::*;
(
	input wire logic core_clk, // 10 MHz clock
	input wire logic rst, // Async reset, high
	input wire logic [15:0] avsAddress, // Byte address
	input wire logic avsRead, // Read strobe
	input wire logic avsWrite, // Write strobe
	input wire logic [31:0] avsWritedata, // Write data
	input wire logic [3:0] avsByteenable, // Byte lanes
	input wire logic avsNonsecure, // Access is non-secure
	output logic [31:0] avsReaddata, // Read data
	output logic avsWaitrequest, // Stall
	input wire cpe_fill_s configFillIn, // Config cache fill
	output cpe_fill_s configFillOut, // Stored config fill
	input wire cpe_fill_s walkFillIn, // Walk cache fill
	output cpe_fill_s walkFillOut, // Stored walk fill
	input wire cpe_use_s configUse, // Config cache lookup
	input wire cpe_use_s walkUse, // Walk cache lookup
	input wire logic secOverride, // Permit value captured after reset release
	output logic rasIrq, // Reliability interrupt
	output logic irq, // Status interrupt
	output logic correctedErr, // Correctable error pulse
	output logic faultMgrRecord // Fault manager record, never
);
	// Answer state: idle then one answer cycle
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK = 2'b10
	} cpe_state_e;

	cpe_state_e state_r, state_nxt;
	logic [3:0] inject_r; // Injection bits
	logic faultIrqEn_r; // Reliability irq enable
	logic nsPermit_r; // Non-secure permit
	logic strapDone_r; // Strap captured after reset
	logic valid_r; // Syndrome valid
	logic ovf_r; // Syndrome overflow
	logic [1:0] ce_r; // Correctable error field
	logic [7:0] src_r; // Error source code
	logic [7:0] serr_r; // Error kind
	logic [EV_W-1:0] evStat_r; // Sticky event status
	logic [EV_W-1:0] evEn_r; // Event enable
	logic [31:0] rdata_r; // Registered read data
	logic rasIrq_r; // Registered reliability irq

	// Byte lane mask from byteenable
	function automatic logic [31:0] laneMask(input logic [3:0] be);
		laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction

	// Request acceptance and decode
	wire logic reqOn = (avsRead | avsWrite) & (state_r == ST_IDLE);
	wire logic [31:0] wmask = laneMask(avsByteenable);
	wire logic [31:0] wd = avsWritedata & wmask;
	// Secure-only register gate and RAS gate
	// RAS access gate
	wire logic rasOk = ~avsNonsecure | nsPermit_r;
	wire logic secOk = ~avsNonsecure;
	wire logic hitInj = avsAddress == INJECT_OFS;
	wire logic hitFc = avsAddress == FAULT_CTRL_OFS;
	wire logic hitSyn = avsAddress == SYNDROME_OFS;
	wire logic hitSec = avsAddress == SEC_CTRL_OFS;
	wire logic hitSt = avsAddress == IRQ_STAT_OFS;
	wire logic hitClr = avsAddress == IRQ_CLR_OFS;
	wire logic hitEn = avsAddress == IRQ_EN_OFS;
	// Writes land at the answer edge, where waitrequest is low
	wire logic wrOn = avsWrite & (state_r == ST_ACK);
	wire logic wrInj = wrOn & hitInj & rasOk;
	wire logic wrFc = wrOn & hitFc & rasOk;
	wire logic wrSyn = wrOn & hitSyn & rasOk;
	wire logic wrSec = wrOn & hitSec & secOk;
	wire logic wrClr = wrOn & hitClr;
	wire logic wrEn = wrOn & hitEn;

	// Wait one cycle, answer in the next
	assign state_nxt = (state_r == ST_IDLE) ?
		(reqOn ? ST_ACK : ST_IDLE) : ST_IDLE;
	assign avsWaitrequest = (avsRead | avsWrite) & (state_r != ST_ACK);
	assign avsReaddata = rdata_r;

	// Fill path: corruption applied as entries are stored
	// Config tag and data corrupt
	cpe_parity_corrupt uCfg (
		.fillIn(configFillIn),
		.tagInject(inject_r[INJ_CCT_BIT]),
		.dataInject(inject_r[INJ_CCD_BIT]),
		.fillOut(configFillOut)
	);
	cpe_parity_corrupt uWalk (
		.fillIn(walkFillIn),
		.tagInject(inject_r[INJ_WCT_BIT]),
		.dataInject(inject_r[INJ_WCD_BIT]),
		.fillOut(walkFillOut)
	);

	// Error detection at lookup time only, config wins over walk
	// Detect on use
	wire logic cfgErr = configUse.valid &
		(configUse.tagBad | configUse.dataBad);
	wire logic walkErr = walkUse.valid & (walkUse.tagBad | walkUse.dataBad);
	wire logic anyErr = cfgErr | walkErr;
	wire logic errTag = cfgErr ? configUse.tagBad : walkUse.tagBad;
	wire logic [7:0] errKind = errTag ? SERR_TAG : SERR_DATA;
	wire logic [7:0] errSrc = cfgErr ? SRC_CONFIG_CACHE :
		{5'h00, walkUse.level & WALK_SRC_MAX};

	// Syndrome clear decode; a recording error wins over a clear
	wire logic clrCe = wrSyn &
		(wd[SYN_CE_LSB +: 2] == CE_CLEAR_CODE) & (~ovf_r | wd[SYN_OVF_BIT]);
	wire logic clrValid = wrSyn & wd[SYN_VALID_BIT] &
		((ce_r == 2'h0) | clrCe);
	wire logic clrOvf = wrSyn & wd[SYN_OVF_BIT];
	// Syndrome record update
	wire logic firstErr = anyErr & ((ce_r == 2'h0) | clrCe);

	// Event status: set wins over clear
	wire logic [EV_W-1:0] evSet = {anyErr & ~firstErr, anyErr & ~errTag,
		anyErr & errTag};
	wire logic [EV_W-1:0] evClr = wrClr ? wd[EV_W-1:0] : '0;
	wire logic [EV_W-1:0] evStat_nxt = (evStat_r & ~evClr) | evSet;

	// Read mux, secured reads return zero
	wire logic [31:0] synWord = {1'b0, valid_r, 2'b00, ovf_r, 1'b0, ce_r,
		8'h00, src_r, serr_r};
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		if (hitInj & rasOk) begin
			rdMux = {28'h0, inject_r};
		end else if (hitFc & rasOk) begin
			rdMux[FAULT_IRQ_EN_BIT] = faultIrqEn_r;
		end else if (hitSyn & rasOk) begin
			rdMux = synWord;
		end else if (hitSec & secOk) begin
			rdMux[PERMIT_BIT] = nsPermit_r;
		end else if (hitSt) begin
			rdMux[EV_W-1:0] = evStat_r;
		end else if (hitEn) begin
			rdMux[EV_W-1:0] = evEn_r;
		end
	end

	// Bus state and read data
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			rdata_r <= 32'h0;
		end else begin
			state_r <= state_nxt;
			rdata_r <= (reqOn & avsRead) ? rdMux : 32'h0;
		end
	end

	// Injection register, upper bits not stored
	// Reset clears injection
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			inject_r <= INJECT_RESET;
		end else if (wrInj) begin
			inject_r <= (inject_r & ~wmask[3:0]) | wd[3:0];
		end
	end

	// Fault control and secure permit; strap taken after reset release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			faultIrqEn_r <= FAULT_IRQ_EN_RESET;
			nsPermit_r <= 1'b0;
			strapDone_r <= 1'b0;
		end else begin
			strapDone_r <= 1'b1;
			if (wrFc) begin
				faultIrqEn_r <= wd[FAULT_IRQ_EN_BIT] |
					(faultIrqEn_r & ~wmask[FAULT_IRQ_EN_BIT]);
			end
			if (!strapDone_r) begin
				nsPermit_r <= secOverride;
			end else if (wrSec & wmask[PERMIT_BIT]) begin
				nsPermit_r <= wd[PERMIT_BIT];
			end
		end
	end

	// Syndrome record; earliest error kept, later ones overflow
	// CE set on error
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			valid_r <= 1'b0;
			ovf_r <= 1'b0;
			ce_r <= 2'h0;
			src_r <= 8'h00;
			serr_r <= SERR_NONE;
		end else begin
			valid_r <= anyErr | (valid_r & ~clrValid);
			ovf_r <= (anyErr & ~firstErr) | (ovf_r & ~clrOvf);
			if (firstErr) begin
				ce_r <= CE_CORRECTED;
				src_r <= errSrc;
				serr_r <= errKind;
			end else if (clrCe) begin
				ce_r <= 2'h0;
				serr_r <= SERR_NONE;
			end
		end
	end

	// Events, enables and interrupt lines
	// Irq gated by enable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			evStat_r <= '0;
			evEn_r <= '0;
			rasIrq_r <= 1'b0;
			correctedErr <= 1'b0;
		end else begin
			evStat_r <= evStat_nxt;
			if (wrEn) begin
				evEn_r <= wd[EV_W-1:0];
			end
			rasIrq_r <= faultIrqEn_r & anyErr;
			correctedErr <= anyErr;
		end
	end

	// Level interrupt from enabled sticky events
	assign irq = |(evStat_r & evEn_r);
	assign rasIrq = rasIrq_r;
	// Injected errors never reach the fault manager records
	assign faultMgrRecord = 1'b0;
endmodule
`default_nettype wire

// ==== tb/cpe_error_injector_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpe_error_injector_chk
	import cpe_pkg::*;
(
	input wire logic core_clk, // Clock
	input wire logic rst, // Reset
	input wire logic avsRead, // Read strobe
	input wire logic avsWrite, // Write strobe
	input wire logic avsWaitrequest, // Stall
	input wire cpe_fill_s configFillIn, // Config fill in
	input wire cpe_fill_s configFillOut, // Config fill out
	input wire cpe_fill_s walkFillIn, // Walk fill in
	input wire cpe_fill_s walkFillOut, // Walk fill out
	input wire cpe_use_s configUse, // Config lookup
	input wire cpe_use_s walkUse, // Walk lookup
	input wire logic rasIrq, // Fault interrupt
	input wire logic correctedErr, // Corrected pulse
	input wire logic faultMgrRecord // Never set
);
	logic useErr; // Any lookup hit a bad entry
	logic req; // Bus request present
	logic [1:0] cfgFlip; // Parity bits inverted now
	logic [1:0] walkFlip; // Parity bits inverted now
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	assign useErr = configUse.valid & (configUse.tagBad | configUse.dataBad)
		| walkUse.valid & (walkUse.tagBad | walkUse.dataBad);
	assign req = avsRead | avsWrite;
	assign cfgFlip = configFillOut[1:0] ^ configFillIn[1:0];
	assign walkFlip = walkFillOut[1:0] ^ walkFillIn[1:0];
	// Flip pattern only moves on a register write
	chk_cfg_inject: assert property (!$past(avsWrite) |->
		cfgFlip == $past(cfgFlip)) else $error("config flip moved");
	chk_walk_inject: assert property (!$past(avsWrite) |->
		walkFlip == $past(walkFlip)) else $error("walk flip moved");
	chk_ce_pulse: assert property (useErr |=> correctedErr)
		else $error("no corrected pulse");
	chk_ce_cause: assert property (correctedErr |-> $past(useErr))
		else $error("corrected pulse without lookup");
	chk_ras_cause: assert property (rasIrq |-> $past(useErr))
		else $error("fault irq without lookup");
	chk_mgr_never: assert property (!faultMgrRecord)
		else $error("fault manager record raised");
	chk_wait_one: assert property (req && avsWaitrequest |=>
		!avsWaitrequest) else $error("answer late");
	chk_wait_back: assert property (req && !avsWaitrequest |=>
		avsWaitrequest || !req) else $error("double answer");
endmodule
bind cpe_error_injector cpe_error_injector_chk chk (.core_clk, .rst,
	.avsRead, .avsWrite, .avsWaitrequest, .configFillIn, .configFillOut,
	.walkFillIn, .walkFillOut, .configUse, .walkUse, .rasIrq,
	.correctedErr, .faultMgrRecord);
`default_nettype wire

// ==== tb/test_cpe_error_injector.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin compares++; if ((a) !== (b)) begin failures++; \
	$display("mismatch %0t got %h", $time, a); end end
module test_cpe_error_injector
	import cpe_pkg::*;
;
	typedef struct packed {
		logic [3:0] inj; // Injection bits
		logic [3:0] exp; // Stored parities c tag,c data,w tag,w data
	} cpe_row_s;
	// Fills carry parity 1, so an injected bit shows as 0
	// Both-bit rows only check parity, never data faults
	cpe_row_s rows [6] = '{'{4'h8, 4'h7}, '{4'h4, 4'hb}, '{4'h2, 4'hd},
		'{4'h1, 4'he}, '{4'hf, 4'h0}, '{4'h0, 4'hf}};
	logic core_clk = 1'b0, rst = 1'b1; // Clock and reset
	logic [15:0] avsAddress = 16'h0; // Bus address
	logic avsRead = 1'b0, avsWrite = 1'b0, avsNonsecure = 1'b0; // Strobes
	logic [31:0] avsWritedata = 32'h0, avsReaddata, q; // Data
	logic [3:0] avsByteenable = 4'hf; // All lanes
	logic avsWaitrequest, secOverride = 1'b0; // Stall, strap
	cpe_fill_s configFillIn = 3'h7, walkFillIn = 3'h7; // Fills
	cpe_fill_s configFillOut, walkFillOut; // Stored fills
	cpe_use_s configUse = 6'h0, walkUse = 6'h0; // Lookups
	logic rasIrq, irq, correctedErr, faultMgrRecord; // Events
	int failures = 0, compares = 0, cyc = 0; // Counters
	cpe_error_injector DUT (.core_clk, .rst, .avsAddress, .avsRead,
		.avsWrite, .avsWritedata, .avsByteenable, .avsNonsecure,
		.avsReaddata, .avsWaitrequest, .configFillIn, .configFillOut,
		.walkFillIn, .walkFillOut, .configUse, .walkUse, .secOverride,
		.rasIrq, .irq, .correctedErr, .faultMgrRecord);
	always #50 core_clk = ~core_clk;
	// Hang guard, far above the run length
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			failures++;
			wrap_up;
		end
	end
	task wrap_up;
		$display("counts failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// One Avalon access, held until waitrequest drops
	task bus(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic ns);
		@(posedge core_clk);
		avsRead <= !w;
		avsWrite <= w;
		avsAddress <= a;
		avsWritedata <= d;
		avsNonsecure <= ns;
		// Sample at rising edges only; leave once waitrequest is low
		do @(posedge core_clk); while (avsWaitrequest !== 1'b0);
		q = avsReaddata;
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(negedge core_clk);
	endtask
	// One lookup pulse, then sit in the following cycle
	task use_err(input logic cfg, input cpe_use_s u);
		@(posedge core_clk);
		if (cfg) configUse <= u;
		else walkUse <= u;
		@(posedge core_clk);
		configUse <= 6'h0;
		walkUse <= 6'h0;
		@(negedge core_clk);
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		bus(0, INJECT_OFS, 32'h0, 0);
		`CHK(q, 32'h0)
		// Each injection pattern, with junk in the upper bits
		foreach (rows[i]) begin
			bus(1, INJECT_OFS, {28'hfffffff, rows[i].inj}, 0);
			bus(0, INJECT_OFS, 32'h0, 0);
			`CHK(q, {28'h0, rows[i].inj})
			`CHK({configFillOut[1:0], walkFillOut[1:0]}, rows[i].exp)
			`CHK(correctedErr, 1'b0)
			$display("row %0d done", i);
		end
		// Tag and data both bad: tag reported, config source
		bus(1, IRQ_EN_OFS, 32'h1, 0);
		use_err(1, '{1'b1, 1'b1, 1'b1, 3'h0});
		`CHK({correctedErr, rasIrq, faultMgrRecord}, 3'b110)
		bus(0, SYNDROME_OFS, 32'h0, 0);
		`CHK(q, 32'h4200_0807)
		`CHK(irq, 1'b1)
		bus(1, IRQ_EN_OFS, 32'h0, 0);
		`CHK(irq, 1'b0)
		bus(1, IRQ_CLR_OFS, 32'h7, 0);
		bus(0, IRQ_STAT_OFS, 32'h0, 0);
		`CHK(q, 32'h0)
		$display("config error done");
		// Walk data error with fault interrupt off
		bus(1, SYNDROME_OFS, 32'h4b00_0000, 0);
		bus(1, FAULT_CTRL_OFS, 32'h0, 0);
		use_err(0, '{1'b1, 1'b0, 1'b1, 3'h5});
		`CHK({correctedErr, rasIrq}, 2'b10)
		bus(0, SYNDROME_OFS, 32'h0, 0);
		`CHK(q, 32'h4200_0508)
		$display("walk error done");
		// Non-secure access refused while permit is clear
		bus(1, INJECT_OFS, 32'h3, 0);
		bus(0, INJECT_OFS, 32'h0, 1);
		`CHK(q, 32'h0)
		bus(1, INJECT_OFS, 32'h0, 1);
		bus(0, INJECT_OFS, 32'h0, 0);
		`CHK(q, 32'h3)
		bus(0, 16'h8ffc, 32'h0, 0);
		`CHK(q, 32'h0)
		$display("access done");
		wrap_up;
	end
endmodule
`default_nettype wire
